// file: shared/uib_defs.vh
// constants for the uart interrupt, break and baud generator block
`ifndef UIB_DEFS_VH
`define UIB_DEFS_VH
// identification codes, bits 5..0
`define UIB_ID_NONE       6'h01
`define UIB_ID_LINE       6'h06
`define UIB_ID_TIMEOUT    6'h0C
`define UIB_ID_RXDATA     6'h04
`define UIB_ID_TXEMPTY    6'h02
`define UIB_ID_MODEM      6'h08
`define UIB_ID_FLOWSTOP   6'h10
`define UIB_ID_PINCHANGE  6'h20
// interrupt enable bit positions
`define UIB_IE_RXDATA     0
`define UIB_IE_TXEMPTY    1
`define UIB_IE_LINE       2
`define UIB_IE_MODEM      3
`define UIB_IE_FLOWSTOP   5
`define UIB_IE_RTS        6
`define UIB_IE_CTS        7
// control bit positions
`define UIB_LINE_BREAK    6
`define UIB_PRESCALE_ON   7
`define UIB_FRAC_X8       7
`define UIB_FRAC_W        6
// timing figures, sized to the arithmetic that uses them
`define UIB_TMO_EXTRA_BITS 6'h0C
`define UIB_TMO_WL_MULT    6'h04
`define UIB_WL_BASE        5'h05
`define UIB_PRESCALE_DIV   4
`define UIB_OVS_X16        16
`define UIB_OVS_X8         8
// reset values
`define UIB_RST_TX         1'b1
`define UIB_RST_LINE_ERR   3'h0
`endif

// file: rtl/uib_baud_gen.v
// fractional baud generator with divide-by-4 prescaler
`timescale 1ns/1ns
`include "uib_defs.vh"
module uib_baud_gen #(
  parameter DIV_W = 16
) (
  input  wire             clk,
  input  wire             rst_sync_n,
  input  wire [DIV_W-1:0] divisor,
  input  wire [5:0]       fraction,
  input  wire             prescale_on,
  output reg              baud_tick
);
  reg  [1:0]       pre_cnt;
  reg  [DIV_W-1:0] div_cnt;
  reg  [5:0]       frac_acc;
  reg              stretch;
  wire             pre_tick;
  wire [DIV_W:0]   period_end;
  wire [6:0]       frac_sum;

  // prescaler passes every clock or every fourth one
  assign pre_tick   = prescale_on ? (pre_cnt == 2'h3) : 1'b1; // see (RULE17)
  // a carry out of the fraction stretches the next period by one
  assign period_end = {1'b0, divisor} + {{DIV_W{1'b0}}, stretch} - {{DIV_W{1'b0}}, 1'b1}; // see (RULE15)
  assign frac_sum   = {1'b0, frac_acc} + {1'b0, fraction};

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pre_cnt   <= 2'h0;
      div_cnt   <= {DIV_W{1'b0}};
      frac_acc  <= 6'h00;
      stretch   <= 1'b0;
      baud_tick <= 1'b0;
    end else begin
      pre_cnt   <= prescale_on ? pre_cnt + 2'h1 : 2'h0;
      baud_tick <= 1'b0;
      // zero divisor: no tick at all, the uart sits idle
      if (divisor == {DIV_W{1'b0}}) begin // see (RULE18)
        div_cnt  <= {DIV_W{1'b0}};
        frac_acc <= 6'h00;
        stretch  <= 1'b0;
      end else if (pre_tick) begin
        if ({1'b0, div_cnt} >= period_end) begin
          div_cnt   <= {DIV_W{1'b0}};
          baud_tick <= 1'b1;
          frac_acc  <= frac_sum[5:0];
          stretch   <= frac_sum[6];
        end else begin
          div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// file: rtl/uib_rx_timeout.v
// receive timeout detector counting idle bit times on the receive line
`timescale 1ns/1ns
`include "uib_defs.vh"
module uib_rx_timeout #(
  parameter CNT_W = 10
) (
  input  wire       clk,
  input  wire       rst_sync_n,
  input  wire       baud_tick,
  input  wire       oversample_x8,
  input  wire [1:0] word_len_sel,
  input  wire       rx_line,
  input  wire       rx_fifo_empty,
  input  wire       rx_pop,
  output reg        timeout_pulse
);
  reg  [CNT_W-1:0] idle_cnt;
  reg              fired;
  wire [4:0]       word_len;
  wire [5:0]       limit_bits;
  wire [CNT_W-1:0] limit_ticks;

  assign word_len    = `UIB_WL_BASE + {3'h0, word_len_sel};
  // 4 x word length + 12 bit periods, at most 44, fits six bits
  assign limit_bits  = (`UIB_TMO_WL_MULT * {1'b0, word_len}) + `UIB_TMO_EXTRA_BITS; // see (RULE13)
  assign limit_ticks = oversample_x8 ? {1'b0, limit_bits, 3'h0} : {limit_bits, 4'h0};

  // restart on any low level, on an empty fifo or on a read
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      idle_cnt      <= {CNT_W{1'b0}};
      fired         <= 1'b0;
      timeout_pulse <= 1'b0;
    end else begin
      timeout_pulse <= 1'b0;
      if (!rx_line || rx_fifo_empty || rx_pop) begin
        idle_cnt <= {CNT_W{1'b0}};
        fired    <= 1'b0;
      end else if (baud_tick && !fired) begin
        if (idle_cnt == limit_ticks - {{(CNT_W-1){1'b0}}, 1'b1}) begin
          timeout_pulse <= 1'b1; // see (RULE13)
          fired         <= 1'b1;
        end else begin
          idle_cnt <= idle_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// file: rtl/uib_irq_top.v
// uart interrupt prioritiser, break control and baud clock top
// How it works
// (RULE1) per-source enables; clearing all silences interrupts
// (RULE2) ident shows pending flag and six-bit code
// (RULE3) line errors give code 000110, top priority
// (RULE4) receive timeout code 001100, cleared by read
// (RULE5) receive data code 000100, cleared by read
// (RULE6) transmit empty code 000010, ident/write clear
// (RULE7) flow stop code 010000, resume or ident clear
// (RULE8) pin inactive edge code 100000, ident clear
// (RULE9) error summary set while errored entries remain
// (RULE10) head entry error flags, zero when empty
// (RULE11) any low enable bit selects interrupt mode
// (RULE12) host polls line status when enables zero
// (RULE13) timeout after 4 x word length + 12 bits
// (RULE14) break control bit forces transmit output low
// (RULE15) divisor 1..65535 with 1/64 fraction steps
// (RULE16) fraction bit 7 picks 8x, else 16x
// (RULE17) modem control bit 7 adds divide-by-4
// (RULE18) zero divisor yields no baud clock
// (RULE19) one generator clocks transmitter and receiver
// (RULE20) flow stop interrupt needs enable bit 5
// (RULE21) ident shows highest enabled pending source
// (RULE22) modem change bits give priority 4 interrupt
`timescale 1ns/1ns
`include "uib_defs.vh"
module uib_irq_top #(
  parameter ERR_CNT_W = 8
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] interrupt_enable_reg,
  input  wire [7:0] line_control_reg,
  input  wire [7:0] modem_control_reg,
  input  wire [7:0] divisor_low_byte,
  input  wire [7:0] divisor_high_byte,
  input  wire [7:0] divisor_fraction_reg,
  input  wire       fifo_enable,
  input  wire       rd_ident,
  input  wire       rd_line_status,
  input  wire       rd_modem_status,
  input  wire       rd_rx_holding,
  input  wire       wr_tx_holding,
  input  wire       rx_data_ready,
  input  wire       rx_fifo_above_trig,
  input  wire       rx_fifo_empty,
  input  wire       rx_push,
  input  wire       rx_push_err,
  input  wire       rx_pop_err,
  input  wire       framing_flag,
  input  wire       parity_flag,
  input  wire       break_flag,
  input  wire       overrun_event,
  input  wire       tx_holding_empty,
  input  wire       tx_fifo_above_trig,
  input  wire [3:0] modem_delta,
  input  wire       xoff_detect,
  input  wire       special_detect,
  input  wire       xon_detect,
  input  wire       rts_pin,
  input  wire       cts_pin,
  input  wire       rx_line,
  input  wire       tx_serial,
  output reg        int_out,
  output reg  [5:0] interrupt_ident_reg,
  output reg        interrupt_mode,
  output reg  [3:0] modem_status_reg,
  output reg        line_err_summary,
  output reg  [2:0] line_status_err,
  output reg        line_overrun,
  output reg        tx_out,
  output reg        sample_tick,
  output reg        oversample_x8
);
  reg                 rst_meta_n;
  reg                 rst_sync_n;
  reg [ERR_CNT_W-1:0] err_cnt;
  reg                 tmo_pend;
  reg                 tx_pend;
  reg                 xoff_pend;
  reg                 special_pend;
  reg                 rts_pend;
  reg                 cts_pend;
  reg                 tx_src_prev;
  reg                 rts_prev;
  reg                 cts_prev;
  reg [5:0]           next_ident;
  reg                 next_int;
  wire                baud_tick;
  wire                tmo_pulse;
  wire                rx_pop;
  wire                tx_src;
  wire                rx_src;
  wire                line_src;
  wire                err_up;
  wire                err_down;
  wire [7:0]          ie;

  // reset released through two flops, asserted at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  assign ie     = interrupt_enable_reg;
  assign rx_pop = rd_rx_holding & ~rx_fifo_empty;

  // one generator serves both directions of the link
  uib_baud_gen #(
    .DIV_W(16)
  ) u_baud (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .divisor    ({divisor_high_byte, divisor_low_byte}), // see (RULE15)
    .fraction   (divisor_fraction_reg[`UIB_FRAC_W-1:0]),
    .prescale_on(modem_control_reg[`UIB_PRESCALE_ON]), // see (RULE17)
    .baud_tick  (baud_tick)
  );

  uib_rx_timeout #(
    .CNT_W(10)
  ) u_tmo (
    .clk          (clk),
    .rst_sync_n   (rst_sync_n),
    .baud_tick    (baud_tick),
    .oversample_x8(divisor_fraction_reg[`UIB_FRAC_X8]),
    .word_len_sel (line_control_reg[1:0]),
    .rx_line      (rx_line),
    .rx_fifo_empty(rx_fifo_empty),
    .rx_pop       (rx_pop),
    .timeout_pulse(tmo_pulse)
  );

  // sampling tick and rate select shared by tx and rx
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sample_tick   <= 1'b0;
      oversample_x8 <= 1'b0;
    end else begin
      sample_tick   <= baud_tick; // see (RULE19)
      oversample_x8 <= divisor_fraction_reg[`UIB_FRAC_X8]; // see (RULE16)
    end
  end

  // break overrides whatever the transmitter shifts out
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_out <= `UIB_RST_TX;
    end else begin
      tx_out <= line_control_reg[`UIB_LINE_BREAK] ? 1'b0 : tx_serial; // see (RULE14)
    end
  end

  // count of errored entries; push and pop in one cycle cancel
  assign err_up   = rx_push & rx_push_err;
  assign err_down = rx_pop & rx_pop_err & (err_cnt != {ERR_CNT_W{1'b0}});
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      err_cnt          <= {ERR_CNT_W{1'b0}};
      line_err_summary <= 1'b0;
      line_status_err  <= `UIB_RST_LINE_ERR;
    end else begin
      if (err_up && !err_down) begin
        err_cnt <= err_cnt + {{(ERR_CNT_W-1){1'b0}}, 1'b1};
      end else if (err_down && !err_up) begin
        err_cnt <= err_cnt - {{(ERR_CNT_W-1){1'b0}}, 1'b1};
      end
      // summary follows the count so it drops only at zero
      line_err_summary <= (err_cnt != {ERR_CNT_W{1'b0}}) || err_up; // see (RULE9)
      // head flags, forced to zero when nothing is held
      line_status_err  <= rx_fifo_empty ? 3'h0 : {break_flag, framing_flag, parity_flag}; // see (RULE10)
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      line_overrun     <= 1'b0;
      tmo_pend         <= 1'b0;
      tx_pend          <= 1'b0;
      xoff_pend        <= 1'b0;
      special_pend     <= 1'b0;
      rts_pend         <= 1'b0;
      cts_pend         <= 1'b0;
      modem_status_reg <= 4'h0;
      tx_src_prev      <= 1'b0;
      rts_prev         <= 1'b1; // pins idle high: no false edge after reset
      cts_prev         <= 1'b1;
    end else begin
      tx_src_prev <= tx_src;
      rts_prev    <= rts_pin;
      cts_prev    <= cts_pin;
      line_overrun     <= overrun_event | (line_overrun & ~rd_line_status); // see (RULE3)
      tmo_pend         <= tmo_pulse | (tmo_pend & ~rd_rx_holding); // see (RULE4)
      // cleared by a holding write or an ident read that reports it
      tx_pend          <= (tx_src & ~tx_src_prev) |
                          (tx_pend & ~wr_tx_holding &
                           ~(rd_ident && interrupt_ident_reg == `UIB_ID_TXEMPTY)); // see (RULE6)
      xoff_pend        <= xoff_detect | (xoff_pend & ~xon_detect); // see (RULE7)
      special_pend     <= special_detect | (special_pend & ~rd_ident); // see (RULE7)
      // rising edge of a pin: active low to inactive high
      rts_pend         <= (rts_pin & ~rts_prev) | (rts_pend & ~rd_ident); // see (RULE8)
      cts_pend         <= (cts_pin & ~cts_prev) | (cts_pend & ~rd_ident); // see (RULE8)
      modem_status_reg <= modem_delta | (modem_status_reg & {4{~rd_modem_status}}); // see (RULE22)
    end
  end

  // tx and rx level sources depend on fifo mode
  assign tx_src   = fifo_enable ? tx_fifo_above_trig : tx_holding_empty; // see (RULE6)
  assign rx_src   = fifo_enable ? rx_fifo_above_trig : rx_data_ready; // see (RULE5)
  assign line_src = line_overrun | line_err_summary; // see (RULE3)

  // priority encoder over enabled sources, highest first
  always @* begin
    next_ident = `UIB_ID_NONE; // see (RULE2)
    next_int   = 1'b1;
    if (line_src && ie[`UIB_IE_LINE]) begin
      next_ident = `UIB_ID_LINE; // see (RULE3)
    end else if (tmo_pend && ie[`UIB_IE_RXDATA]) begin
      next_ident = `UIB_ID_TIMEOUT; // see (RULE4)
    end else if (rx_src && ie[`UIB_IE_RXDATA]) begin
      next_ident = `UIB_ID_RXDATA; // see (RULE5)
    end else if (tx_pend && ie[`UIB_IE_TXEMPTY]) begin
      next_ident = `UIB_ID_TXEMPTY; // see (RULE6)
    end else if ((modem_status_reg != 4'h0) && ie[`UIB_IE_MODEM]) begin
      next_ident = `UIB_ID_MODEM; // see (RULE22)
    end else if ((xoff_pend || special_pend) && ie[`UIB_IE_FLOWSTOP]) begin
      next_ident = `UIB_ID_FLOWSTOP; // see (RULE20)
    end else if ((rts_pend && ie[`UIB_IE_RTS]) || (cts_pend && ie[`UIB_IE_CTS])) begin
      next_ident = `UIB_ID_PINCHANGE; // see (RULE8)
    end else begin
      next_int = 1'b0; // see (RULE1)
    end
  end

  // registered outputs; bit 0 of ident low means pending
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      interrupt_ident_reg <= `UIB_ID_NONE;
      int_out             <= 1'b0;
      interrupt_mode      <= 1'b0;
    end else begin
      interrupt_ident_reg <= next_ident; // see (RULE21)
      int_out             <= next_int; // see (RULE21)
      // polled mode when all four low enables are clear
      interrupt_mode      <= |ie[3:0]; // see (RULE11)
    end
  end
endmodule

// file: dv/uib_irq_sva.sv
// assertion checker for the interrupt, break and baud block
`timescale 1ns/1ns
`include "uib_defs.vh"
module uib_irq_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [7:0] line_control_reg,
  input wire logic [7:0] modem_control_reg,
  input wire logic [7:0] divisor_low_byte,
  input wire logic [7:0] divisor_high_byte,
  input wire logic [7:0] divisor_fraction_reg,
  input wire logic       rd_line_status,
  input wire logic       overrun_event,
  input wire logic       rx_fifo_empty,
  input wire logic       tx_serial,
  input wire logic [3:0] modem_delta,
  input wire logic       int_out,
  input wire logic [5:0] interrupt_ident_reg,
  input wire logic       interrupt_mode,
  input wire logic [3:0] modem_status_reg,
  input wire logic [2:0] line_status_err,
  input wire logic       line_overrun,
  input wire logic       tx_out,
  input wire logic       sample_tick,
  input wire logic       oversample_x8
);
  // divisor views; div_two also needs no fraction and no prescale
  wire [15:0] div    = {divisor_high_byte, divisor_low_byte};
  wire        div_two = div == 16'h0002 && divisor_fraction_reg[5:0] == 6'h00 && !modem_control_reg[7];
  wire        ie_off  = interrupt_enable_reg[3:0] == 4'h0 && interrupt_enable_reg[7:5] == 3'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // multi-step behaviours
  sequence s_ovr_set; overrun_event ##1 (line_overrun && interrupt_enable_reg[2]); endsequence
  sequence s_div2_tick; div_two [*4] ##0 sample_tick; endsequence
  property p_any_pend; int_out == (interrupt_ident_reg != `UIB_ID_NONE); endproperty
  a_any_pend: assert property (p_any_pend) else $error("int_out and ident disagree");
  property p_all_off; ie_off [*3] |-> !int_out; endproperty
  a_all_off: assert property (p_all_off) else $error("int_out with all enables clear");
  property p_mode; interrupt_mode == |$past(interrupt_enable_reg[3:0]); endproperty
  a_mode: assert property (p_mode) else $error("interrupt_mode wrong");
  property p_ovr_flag; overrun_event |=> line_overrun; endproperty
  a_ovr_flag: assert property (p_ovr_flag) else $error("overrun not flagged");
  property p_ovr_code; s_ovr_set |=> interrupt_ident_reg == `UIB_ID_LINE; endproperty
  a_ovr_code: assert property (p_ovr_code) else $error("overrun code missing");
  property p_ovr_clr; rd_line_status && !overrun_event |=> !line_overrun; endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun kept after status read");
  property p_brk; line_control_reg[`UIB_LINE_BREAK] |=> !tx_out; endproperty
  a_brk: assert property (p_brk) else $error("break not driven low");
  property p_pass; !line_control_reg[`UIB_LINE_BREAK] |=> tx_out == $past(tx_serial); endproperty
  a_pass: assert property (p_pass) else $error("tx_out not following shifter");
  property p_empty; rx_fifo_empty [*2] |-> line_status_err == 3'h0; endproperty
  a_empty: assert property (p_empty) else $error("error flags with empty fifo");
  property p_x8; (divisor_fraction_reg[`UIB_FRAC_X8]) [*2] |-> oversample_x8; endproperty
  a_x8: assert property (p_x8) else $error("8x select not shown");
  property p_nodiv; (div == 16'h0000) [*3] |-> !sample_tick; endproperty
  a_nodiv: assert property (p_nodiv) else $error("tick with zero divisor");
  property p_div2; s_div2_tick |=> !sample_tick ##1 (sample_tick || !div_two); endproperty
  a_div2: assert property (p_div2) else $error("divide by two rate wrong");
  property p_msr;
    (modem_delta != 4'h0) |=> (modem_status_reg & $past(modem_delta)) == $past(modem_delta);
  endproperty
  a_msr: assert property (p_msr) else $error("modem change bit not set");
endmodule
bind uib_irq_top uib_irq_sva u_sva (.clk, .rst_n, .interrupt_enable_reg, .line_control_reg, .modem_control_reg,
  .divisor_low_byte, .divisor_high_byte, .divisor_fraction_reg, .rd_line_status, .overrun_event, .rx_fifo_empty,
  .tx_serial, .modem_delta, .int_out, .interrupt_ident_reg, .interrupt_mode, .modem_status_reg, .line_status_err,
  .line_overrun, .tx_out, .sample_tick, .oversample_x8);

// file: dv/uib_far_uart.sv
// remote uart model on the serial lines
`timescale 1ns/1ns
module uib_far_uart (
  input  wire logic clk,
  input  wire logic tx_out,
  input  wire logic send_start,
  output logic      rx_line,
  output int        low_cycles
);
  // mark level between frames, space only for a requested start bit
  assign rx_line = !send_start;
  // run of space on the line we hear; a long run means break
  always @(posedge clk) low_cycles <= tx_out ? 0 : low_cycles + 1;
endmodule

// file: dv/tb.sv
// testbench for the interrupt, break and baud block
`timescale 1ns/1ns
`include "uib_defs.vh"
module tb;
  logic       clk, rst_n, fifo_enable, rd_ident, rd_line_status, rd_modem_status, rd_rx_holding, wr_tx_holding;
  logic [7:0] interrupt_enable_reg, line_control_reg, modem_control_reg;
  logic [7:0] divisor_low_byte, divisor_high_byte, divisor_fraction_reg;
  logic       rx_data_ready, rx_fifo_above_trig, rx_fifo_empty, rx_push, rx_push_err, rx_pop_err;
  logic       framing_flag, parity_flag, break_flag, overrun_event, tx_holding_empty, tx_fifo_above_trig;
  logic       xoff_detect, special_detect, xon_detect, rts_pin, cts_pin, rx_line, tx_serial, send_start;
  logic [3:0] modem_delta, modem_status_reg;
  logic [5:0] interrupt_ident_reg;
  logic [2:0] line_status_err;
  logic       int_out, interrupt_mode, line_err_summary, line_overrun, tx_out, sample_tick, oversample_x8;
  int         fails, n_tests, low_cycles, cnt;
  // divisor, fraction, prescale, window, expected ticks
  int         bt [6][5] = '{'{1, 128, 0, 20, 20}, '{2, 0, 0, 64, 32}, '{3, 0, 1, 120, 10},
                            '{2, 32, 0, 160, 64}, '{258, 0, 0, 516, 2}, '{0, 0, 0, 100, 0}};

  uib_irq_top uut (.clk, .rst_n, .interrupt_enable_reg, .line_control_reg, .modem_control_reg, .divisor_low_byte,
    .divisor_high_byte, .divisor_fraction_reg, .fifo_enable, .rd_ident, .rd_line_status, .rd_modem_status,
    .rd_rx_holding, .wr_tx_holding, .rx_data_ready, .rx_fifo_above_trig, .rx_fifo_empty, .rx_push, .rx_push_err,
    .rx_pop_err, .framing_flag, .parity_flag, .break_flag, .overrun_event, .tx_holding_empty, .tx_fifo_above_trig,
    .modem_delta, .xoff_detect, .special_detect, .xon_detect, .rts_pin, .cts_pin, .rx_line, .tx_serial, .int_out,
    .interrupt_ident_reg, .interrupt_mode, .modem_status_reg, .line_err_summary, .line_status_err, .line_overrun,
    .tx_out, .sample_tick, .oversample_x8);
  uib_far_uart far (.clk, .tx_out, .send_start, .rx_line, .low_cycles);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [5:0] e, input logic [5:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_n(input string nm, input int e, input int g);
    n_tests++;
    if (g != e) begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // one-cycle strobe, then the identification code two edges on
  task automatic ev(ref logic s, input logic [5:0] e);
    s = 1'b1;
    wt(1);
    s = 1'b0;
    wt(2);
    chk("ident", e, interrupt_ident_reg);
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report;
  end

  // main sequence; divisor stays zero until the baud part so no timeout fires early
  initial begin
    {interrupt_enable_reg, line_control_reg, modem_control_reg, divisor_low_byte, divisor_high_byte} = '0;
    {divisor_fraction_reg, fifo_enable, rd_ident, rd_line_status, rd_modem_status, rd_rx_holding} = '0;
    {wr_tx_holding, rx_data_ready, rx_fifo_above_trig, rx_push, rx_push_err, rx_pop_err, framing_flag} = '0;
    {parity_flag, break_flag, overrun_event, tx_holding_empty, tx_fifo_above_trig, modem_delta} = '0;
    {xoff_detect, special_detect, xon_detect, rts_pin, cts_pin, send_start, rst_n, fails, n_tests} = '0;
    {rx_fifo_empty, tx_serial} = 2'b11;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    wt(3);
    chk("ident", `UIB_ID_NONE, interrupt_ident_reg);
    chk("tx_out", 6'h01, {5'h00, tx_out});
    interrupt_enable_reg = 8'h04;
    ev(overrun_event, `UIB_ID_LINE);
    chk("int_out", 6'h01, {5'h00, int_out});
    ev(rd_line_status, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h10;
    ev(overrun_event, `UIB_ID_NONE);
    chk("polled", 6'h02, {4'h0, line_overrun, interrupt_mode});
    ev(rd_line_status, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h04;
    rx_fifo_empty = 1'b0;
    rx_push_err = 1'b1;
    ev(rx_push, `UIB_ID_LINE);
    ev(rx_push, `UIB_ID_LINE);
    {rx_push_err, rx_pop_err} = 2'b01;
    ev(rd_rx_holding, `UIB_ID_LINE);
    ev(rd_rx_holding, `UIB_ID_NONE);
    chk("err_sum", 6'h00, {5'h00, line_err_summary});
    {rx_pop_err, break_flag, framing_flag, parity_flag} = 4'b0101;
    wt(3);
    chk("line_err", 6'h05, {3'h0, line_status_err});
    rx_fifo_empty = 1'b1;
    wt(3);
    chk("line_err", 6'h00, {3'h0, line_status_err});
    {break_flag, framing_flag, parity_flag, rx_fifo_empty} = 4'b0000;
    interrupt_enable_reg = 8'h01;
    for (int m = 0; m < 2; m++) begin
      fifo_enable = m[0];
      {rx_fifo_above_trig, rx_data_ready} = m[0] ? 2'b10 : 2'b01;
      wt(3);
      chk("ident", `UIB_ID_RXDATA, interrupt_ident_reg);
      {rx_fifo_above_trig, rx_data_ready} = 2'b00;
      ev(rd_rx_holding, `UIB_ID_NONE);
    end
    {fifo_enable, rx_fifo_empty} = 2'b01;
    interrupt_enable_reg = 8'h02;
    ev(tx_holding_empty, `UIB_ID_TXEMPTY);
    ev(rd_ident, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h0A;
    ev(tx_holding_empty, `UIB_ID_TXEMPTY);
    // a bit of a vector cannot be a ref argument, so pulse it here
    modem_delta = 4'h2;
    wt(1);
    modem_delta = 4'h0;
    wt(2);
    chk("ident", `UIB_ID_TXEMPTY, interrupt_ident_reg);
    chk("modem_status", 6'h02, {2'h0, modem_status_reg});
    ev(wr_tx_holding, `UIB_ID_MODEM);
    ev(rd_modem_status, `UIB_ID_NONE);
    fifo_enable = 1'b1;
    ev(tx_fifo_above_trig, `UIB_ID_TXEMPTY);
    ev(rd_ident, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h20;
    ev(xoff_detect, `UIB_ID_FLOWSTOP);
    ev(rd_ident, `UIB_ID_FLOWSTOP);
    ev(xon_detect, `UIB_ID_NONE);
    ev(special_detect, `UIB_ID_FLOWSTOP);
    ev(rd_ident, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h01;
    ev(xoff_detect, `UIB_ID_NONE);
    chk("int_out", 6'h00, {5'h00, int_out});
    ev(xon_detect, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h40;
    ev(rts_pin, `UIB_ID_PINCHANGE);
    ev(rd_ident, `UIB_ID_NONE);
    interrupt_enable_reg = 8'h80;
    ev(cts_pin, `UIB_ID_PINCHANGE);
    ev(rd_ident, `UIB_ID_NONE);
    line_control_reg = 8'h40;
    wt(10);
    chk("brk_len", 6'h01, {5'h00, low_cycles >= 9 && tx_out === 1'b0});
    // break released with the shifter high: the line must rise again
    {line_control_reg, tx_serial} = 9'h001;
    wt(2);
    chk("tx_out", 6'h01, {5'h00, tx_out});
    // one generator for both directions: rate per table row
    foreach (bt[i]) begin
      {divisor_high_byte, divisor_low_byte} = 16'(bt[i][0]);
      divisor_fraction_reg = 8'(bt[i][1]);
      modem_control_reg = bt[i][2] ? 8'h80 : 8'h00;
      wt(300);
      cnt = 0;
      repeat (bt[i][3]) begin
        @(negedge clk);
        if (sample_tick === 1'b1) cnt++;
      end
      chk_n("ticks", bt[i][4], cnt);
      chk("x8", {5'h00, divisor_fraction_reg[7]}, {5'h00, oversample_x8});
    end
    // idle line with stale data: (4*5+12) bits at 8 ticks each, divisor 1
    {divisor_high_byte, divisor_low_byte, divisor_fraction_reg} = 24'h000180;
    {interrupt_enable_reg, rx_fifo_empty, send_start} = 10'h005;
    wt(1);
    {send_start, cnt} = '0;
    while (interrupt_ident_reg !== `UIB_ID_TIMEOUT && cnt < 400) begin
      wt(1);
      cnt++;
    end
    chk("tmo_time", 6'h01, {5'h00, cnt >= 256 && cnt <= 266});
    ev(rd_rx_holding, `UIB_ID_NONE);
    final_report;
  end
endmodule
